// *** rtl/fpcw_core.v ***
`include "fpcw_map.vh"

// Every issue answers exactly one enabled cycle later; there is no stall path.
// Unpredictable selections and reserved source bits leave the status untouched.
// That keeps privileged state safe, at the cost of silently ignoring bad code.
// Rounding itself lives in the external datapath; this block only routes it.
// The status register is written on the same edge the exception is flagged,
// so a handler always sees the word that caused the trap.
// Clock enable low freezes every flop, pulses included, so a caller that
// counts pulses must only count them in enabled cycles.
// Partial views merge into the one status register; there is no shadow copy,
// so a view write and a full write can never disagree.
// The second coprocessor only ever sees its strobes and held fields.
// Its fields move only on an accepted issue, which keeps them stable
// while the coprocessor decodes them.
module fpcw_core #(
	parameter IMPL_FIELD_PRESENT = 1,
	parameter CP2_PRESENT = 1,
	parameter LONG_PRESENT = 1
) (
	// Clock, reset and global freeze
	input wire REF_CLK_IN,
	input wire RST_B_IN,
	input wire CLK_EN_IN,
	// Instruction issue from the pipeline
	input wire ISSUE_VALID_IN,
	input wire [2:0] ISSUE_OP_IN,
	input wire [31:0] ISSUE_PC_IN,
	// Instruction fields
	input wire [4:0] FLOAT_SOURCE_REGISTER_IN,
	input wire [4:0] FORMAT_IN,
	input wire [15:0] IMPL_FIELD_IN,
	input wire [24:0] COFUN_IN,
	// Operands
	input wire [63:0] GENERAL_REGISTER_IN,
	input wire [63:0] FLOAT_SOURCE_IN,
	input wire [63:0] FLOAT_SECOND_SOURCE_IN,
	// Rounded result and invalid condition from the datapath
	input wire [63:0] CONVERT_RESULT_IN,
	input wire CONVERT_INVALID_IN,
	// Coprocessor enables, high means usable
	input wire COP1_USABLE_IN,
	input wire SECOND_COPROC_OPERATION_USABLE_IN,
	// Status register copy
	output reg [31:0] FP_CONTROL_STATUS_OUT,
	// Destination float register write
	output reg DEST_WRITE_OUT,
	output reg [63:0] DEST_DATA_OUT,
	// Current rounding mode for the datapath
	output reg [1:0] ROUND_MODE_OUT,
	// Exception pulses and the faulting address
	output reg FP_EXCEPTION_OUT,
	output reg UNUSABLE_EXCEPTION_OUT,
	output reg RESERVED_EXCEPTION_OUT,
	output reg [31:0] EXCEPTION_RETURN_ADDRESS_OUT,
	// Second coprocessor strobes and held fields
	output reg CP2_CTRL_WRITE_OUT,
	output reg CP2_OPER_OUT,
	output reg [15:0] CP2_SELECT_OUT,
	output reg [31:0] CP2_DATA_OUT,
	output reg [24:0] CP2_FUNC_OUT,
	// One pulse per taken issue
	output reg DONE_OUT
);
	// Status register and its next value
	reg [31:0] status_ff;
	reg [31:0] nxt_status;
	// Low word of the selected general register
	wire [31:0] word;
	// Decode results for the current issue
	reg wr_ok;
	reg trap;
	reg unusable;
	reg reserved;
	reg dest_wr;
	reg [63:0] dest_data;
	// Six exception kinds; the last one has no enable bit
	localparam N_CAUSE = 6;
	// Cause and enable fields before and after the write
	wire [5:0] cause_now;
	wire [5:0] cause_nxt;
	wire [5:0] en_now;
	wire [5:0] en_nxt;
	// A pair is armed when its cause and its enable are both set
	wire [5:0] old_armed;
	wire [5:0] new_armed;
	// Instruction class
	wire is_move;
	wire is_cp2;
	wire is_conv;
	// Second coprocessor issue that passed the availability checks
	wire cp2_go;
	// Reserved source bits clear for each control register view
	wire cond_legal;
	wire exv_legal;
	wire env_legal;
	wire full_legal;
	// Status word each partial view would produce
	wire [31:0] cond_word;
	wire [31:0] exv_word;
	wire [31:0] env_word;
	// Any exception raised by this issue
	wire any_exc;

	assign is_move = (ISSUE_OP_IN == `FPCW_OP_MOVE_CTRL);
	assign is_cp2 = (ISSUE_OP_IN == `FPCW_OP_CP2_CTRL) || (ISSUE_OP_IN == `FPCW_OP_CP2_OPER);
	assign is_conv = ISSUE_OP_IN[2];

	// Cause field is six wide; the unimplemented cause has no enable bit
	assign cause_now = status_ff[`FPCW_CAUSE_LO+5:`FPCW_CAUSE_LO];
	assign cause_nxt = nxt_status[`FPCW_CAUSE_LO+5:`FPCW_CAUSE_LO];

	// Per exception kind: enable before and after, and the armed pair
	genvar gi;
	generate
		for (gi = 0; gi < N_CAUSE; gi = gi + 1) begin : g_arm
			if (gi == N_CAUSE - 1) begin : g_unimpl
				// Unimplemented can never be masked, so it is armed whenever its cause is set
				assign en_now[gi] = 1'b1;
				assign en_nxt[gi] = 1'b1;
			end else begin : g_masked
				assign en_now[gi] = status_ff[`FPCW_EN_LO+gi];
				assign en_nxt[gi] = nxt_status[`FPCW_EN_LO+gi];
			end
			assign old_armed[gi] = cause_now[gi] & en_now[gi];
			assign new_armed[gi] = cause_nxt[gi] & en_nxt[gi];
		end
	endgenerate

	// Low word only; the upper half of a wide register is ignored
	assign word = GENERAL_REGISTER_IN[31:0];

	// Reserved source bits must be clear, else the write is dropped
	assign cond_legal = (word[31:8] == 24'h000000);
	assign exv_legal = (word[31:18] == 14'h0000) && (word[11:7] == 5'h00) && (word[1:0] == 2'h0);
	assign env_legal = (word[31:12] == 20'h00000) && (word[6:3] == 4'h0);
	// Which high bits are reserved depends on the implementation field
	assign full_legal = (IMPL_FIELD_PRESENT != 0) ? (word[20:18] == 3'h0) : (word[22:18] == 5'h00);

	// Condition view: seven condition codes on top, one just below the flush bit
	assign cond_word = {word[7:1], status_ff[24], word[0], status_ff[22:0]};
	// Exception view: causes and flags only, everything else kept
	assign exv_word = {status_ff[31:18], word[17:12], status_ff[11:7], word[6:2], status_ff[1:0]};
	// Enable view: flush bit, enables and rounding mode, everything else kept
	assign env_word = {status_ff[31:25], word[2], status_ff[23:12], word[11:7], status_ff[6:2], word[1:0]};

	// Strobes to the second coprocessor only once it is known present and usable
	assign cp2_go = ISSUE_VALID_IN && is_cp2 && (CP2_PRESENT != 0) && SECOND_COPROC_OPERATION_USABLE_IN;
	assign any_exc = trap || unusable || reserved;

	// Decode the issued instruction and form the next status word
	always @* begin
		nxt_status = status_ff;
		wr_ok = 1'b0;
		trap = 1'b0;
		unusable = 1'b0;
		reserved = 1'b0;
		dest_wr = 1'b0;
		dest_data = CONVERT_RESULT_IN;
		if (ISSUE_VALID_IN) begin
			// Coprocessor availability checked before any effect
			if (is_cp2 && !CP2_PRESENT) begin
				reserved = 1'b1;
			end else if (is_cp2 && !SECOND_COPROC_OPERATION_USABLE_IN) begin
				unusable = 1'b1;
			end else if ((is_move || is_conv) && !COP1_USABLE_IN) begin
				unusable = 1'b1;
			end else if (is_move) begin
				// Unpredictable selections or reserved bits leave the status alone
				case (FLOAT_SOURCE_REGISTER_IN)
					`FPCW_SEL_CONDITION: begin
						if (cond_legal) begin
							nxt_status = cond_word;
							wr_ok = 1'b1;
						end
					end

					`FPCW_SEL_EXCEPTION: begin
						if (exv_legal) begin
							nxt_status = exv_word;
							wr_ok = 1'b1;
						end
					end

					`FPCW_SEL_ENABLE: begin
						if (env_legal) begin
							nxt_status = env_word;
							wr_ok = 1'b1;
						end
					end

					`FPCW_SEL_STATUS: begin
						if (full_legal) begin
							nxt_status = word;
							wr_ok = 1'b1;
						end
					end

					default: begin
						// Nonexistent register: nothing written, no trap, still done
						wr_ok = 1'b0;
					end
				endcase
				// Full write traps on any armed pair; view writes only on a newly armed pair
				if (wr_ok && FLOAT_SOURCE_REGISTER_IN == `FPCW_SEL_STATUS) begin
					trap = |new_armed;
				end else if (wr_ok) begin
					trap = |(new_armed & ~old_armed);
				end
			end else if (is_conv) begin
				case (ISSUE_OP_IN)
					`FPCW_OP_TO_DOUBLE: begin
						// Result from the rounding datapath; single and word inputs are exact
						if (FORMAT_IN == `FPCW_FMT_S || FORMAT_IN == `FPCW_FMT_W ||
							(FORMAT_IN == `FPCW_FMT_L && LONG_PRESENT)) begin
							dest_wr = 1'b1;
						end else begin
							reserved = 1'b1;
						end
					end

					// Long results need the full float register file
					`FPCW_OP_TO_LONG: begin
						if (LONG_PRESENT && (FORMAT_IN == `FPCW_FMT_S || FORMAT_IN == `FPCW_FMT_D)) begin
							dest_wr = 1'b1;
							// Flag and cause both record the invalid condition
							if (CONVERT_INVALID_IN) begin
								nxt_status[`FPCW_FLAG_LO+`FPCW_INVALID_BIT] = 1'b1;
								nxt_status[`FPCW_CAUSE_LO+`FPCW_INVALID_BIT] = 1'b1;
								if (status_ff[`FPCW_EN_LO+`FPCW_INVALID_BIT]) begin
									dest_wr = 1'b0;
									trap = 1'b1;
								end else begin
									dest_data = `FPCW_LONG_MAX;
								end
							end
						end else begin
							reserved = 1'b1;
						end
					end

					// Pure move of two singles; no rounding and no flags
					`FPCW_OP_PAIR: begin
						if (LONG_PRESENT) begin
							dest_wr = 1'b1;
							dest_data = {FLOAT_SOURCE_IN[31:0], FLOAT_SECOND_SOURCE_IN[31:0]};
						end else begin
							reserved = 1'b1;
						end
					end

					// Only convert-to-single is left; a single source is not a legal format
					default: begin
						if (FORMAT_IN == `FPCW_FMT_D || FORMAT_IN == `FPCW_FMT_W ||
							(FORMAT_IN == `FPCW_FMT_L && LONG_PRESENT)) begin
							dest_wr = 1'b1;
						end else begin
							reserved = 1'b1;
						end
					end
				endcase
			end else if (ISSUE_OP_IN == `FPCW_OP_NONE) begin
				reserved = 1'b0;
			end
		end
	end

	// Status register and exception reporting; clock enable freezes everything
	always @(posedge REF_CLK_IN or negedge RST_B_IN) begin
		if (!RST_B_IN) begin
			status_ff <= `FPCW_STATUS_RST;
			FP_CONTROL_STATUS_OUT <= `FPCW_STATUS_RST;
			ROUND_MODE_OUT <= 2'h0;
			FP_EXCEPTION_OUT <= 1'b0;
			UNUSABLE_EXCEPTION_OUT <= 1'b0;
			RESERVED_EXCEPTION_OUT <= 1'b0;
			EXCEPTION_RETURN_ADDRESS_OUT <= 32'h00000000;
			DONE_OUT <= 1'b0;
		end else if (CLK_EN_IN) begin
			// Register written in the same edge the exception is flagged
			status_ff <= nxt_status;
			FP_CONTROL_STATUS_OUT <= nxt_status;
			ROUND_MODE_OUT <= nxt_status[`FPCW_RM_LO+1:`FPCW_RM_LO];
			FP_EXCEPTION_OUT <= trap;
			UNUSABLE_EXCEPTION_OUT <= unusable;
			RESERVED_EXCEPTION_OUT <= reserved;
			// Address held until the next faulting issue
			if (any_exc) begin
				EXCEPTION_RETURN_ADDRESS_OUT <= ISSUE_PC_IN;
			end
			// Every taken issue ends in one cycle, so the pipeline never waits
			DONE_OUT <= ISSUE_VALID_IN;
		end
	end

	// Destination write towards the float register file
	always @(posedge REF_CLK_IN or negedge RST_B_IN) begin
		if (!RST_B_IN) begin
			DEST_WRITE_OUT <= 1'b0;
			DEST_DATA_OUT <= 64'h0000000000000000;
		end else if (CLK_EN_IN) begin
			// A trapped conversion leaves the destination unwritten
			DEST_WRITE_OUT <= dest_wr;
			DEST_DATA_OUT <= dest_data;
		end
	end

	// Second coprocessor side; no processor state moves here
	always @(posedge REF_CLK_IN or negedge RST_B_IN) begin
		if (!RST_B_IN) begin
			CP2_CTRL_WRITE_OUT <= 1'b0;
			CP2_OPER_OUT <= 1'b0;
			CP2_SELECT_OUT <= 16'h0000;
			CP2_DATA_OUT <= 32'h00000000;
			CP2_FUNC_OUT <= 25'h0000000;
		end else if (CLK_EN_IN) begin
			CP2_CTRL_WRITE_OUT <= cp2_go && (ISSUE_OP_IN == `FPCW_OP_CP2_CTRL);
			CP2_OPER_OUT <= cp2_go && (ISSUE_OP_IN == `FPCW_OP_CP2_OPER);
			// Fields only move on an accepted issue, so the coprocessor sees stable values
			if (cp2_go) begin
				CP2_SELECT_OUT <= IMPL_FIELD_IN;
				CP2_DATA_OUT <= word;
				CP2_FUNC_OUT <= COFUN_IN;
			end
		end
	end
endmodule

// *** rtl/fpcw_map.vh ***
`ifndef FPCW_MAP_VH
`define FPCW_MAP_VH
// Control register numbers selected by the source-register field
`define FPCW_SEL_CONDITION 5'h19
`define FPCW_SEL_EXCEPTION 5'h1a
`define FPCW_SEL_ENABLE 5'h1c
`define FPCW_SEL_STATUS 5'h1f
// Status register reset value
`define FPCW_STATUS_RST 32'h00000000
// Status field positions
`define FPCW_RM_LO 0
`define FPCW_FLAG_LO 2
`define FPCW_EN_LO 7
`define FPCW_CAUSE_LO 12
`define FPCW_INVALID_BIT 4
// Operation codes presented by the pipeline
`define FPCW_OP_NONE 3'h0
`define FPCW_OP_MOVE_CTRL 3'h1
`define FPCW_OP_CP2_CTRL 3'h2
`define FPCW_OP_CP2_OPER 3'h3
`define FPCW_OP_TO_DOUBLE 3'h4
`define FPCW_OP_TO_LONG 3'h5
`define FPCW_OP_PAIR 3'h6
`define FPCW_OP_TO_SINGLE 3'h7
// Source format codes
`define FPCW_FMT_S 5'h10
`define FPCW_FMT_D 5'h11
`define FPCW_FMT_W 5'h14
`define FPCW_FMT_L 5'h15
// Default long result for an invalid conversion
`define FPCW_LONG_MAX 64'h7fffffffffffffff
`endif

// *** verif/fpcw_arith_model.sv ***
module fpcw_arith_model (
	input wire logic [63:0] src_in,
	output logic [63:0] res_out,
	output logic inv_out
);
	timeunit 1ns;
	timeprecision 1ps;
	// Stand-in datapath: halves swapped so each result traces back to its source
	assign res_out = {src_in[31:0], src_in[63:32]};
	// All-ones exponent is infinity or NaN, which no fixed format can hold
	assign inv_out = &src_in[62:52];
endmodule

// *** verif/fpcw_core_chk.sv ***
module fpcw_core_chk (
	input logic REF_CLK_IN,
	input logic RST_B_IN,
	input logic CLK_EN_IN,
	input logic ISSUE_VALID_IN,
	input logic [2:0] ISSUE_OP_IN,
	input logic [31:0] ISSUE_PC_IN,
	input logic [4:0] FLOAT_SOURCE_REGISTER_IN,
	input logic [63:0] GENERAL_REGISTER_IN,
	input logic COP1_USABLE_IN,
	input logic [31:0] FP_CONTROL_STATUS_OUT,
	input logic FP_EXCEPTION_OUT,
	input logic UNUSABLE_EXCEPTION_OUT,
	input logic [31:0] EXCEPTION_RETURN_ADDRESS_OUT,
	input logic DONE_OUT
);
	timeunit 1ns;
	timeprecision 1ps;
	// Shorthands for a taken issue, a usable control move, its word and the status
	wire tk = CLK_EN_IN && ISSUE_VALID_IN;
	wire mv = tk && COP1_USABLE_IN && ISSUE_OP_IN == 3'h1;
	wire [4:0] s = FLOAT_SOURCE_REGISTER_IN;
	wire [31:0] g = GENERAL_REGISTER_IN[31:0];
	wire [31:0] f = FP_CONTROL_STATUS_OUT;
	default clocking @(posedge REF_CLK_IN);
	endclocking
	default disable iff (!RST_B_IN);
	property p_done; tk |=> DONE_OUT; endproperty
	a_done: assert property (p_done) else $error("no done");
	property p_full; mv && s == 5'h1f && g[20:18] == 3'h0 |=> f == $past(g); endproperty
	a_full: assert property (p_full) else $error("bad full write");
	property p_cond; mv && s == 5'h19 && g[31:8] == 24'h0 |=> f == {$past(g[7:1]), $past(f[24]), $past(g[0]), $past(f[22:0])};
	endproperty
	a_cond: assert property (p_cond) else $error("bad condition view");
	property p_exv; mv && s == 5'h1a && g[31:18] == 14'h0 && g[11:7] == 5'h0 && g[2:0] == 3'h0
		|=> f == ($past(f) & 32'hfffc0f83 | $past(g)); endproperty
	a_exv: assert property (p_exv) else $error("bad exception view");
	property p_env; mv && s == 5'h1c && g[31:12] == 20'h0 && g[6:3] == 4'h0
		|=> f == ($past(f) & 32'hfefff07c | $past(g) & 32'hf83 | {7'h0, $past(g[2]), 24'h0}); endproperty
	a_env: assert property (p_env) else $error("bad enable view");
	property p_trap; mv && s == 5'h1f && g[20:18] == 3'h0 && (g[16:12] & g[11:7]) != 5'h0
		|=> FP_EXCEPTION_OUT && EXCEPTION_RETURN_ADDRESS_OUT == $past(ISSUE_PC_IN); endproperty
	a_trap: assert property (p_trap) else $error("no trap");
	property p_unus; tk && !COP1_USABLE_IN && ISSUE_OP_IN == 3'h1 |=> UNUSABLE_EXCEPTION_OUT && $stable(f); endproperty
	a_unus: assert property (p_unus) else $error("no unusable");
	property p_hold; !tk |=> $stable(f) && !DONE_OUT; endproperty
	a_hold: assert property (p_hold) else $error("idle change");
	c_trap: cover property (mv ##1 FP_EXCEPTION_OUT);
	c_unus: cover property (UNUSABLE_EXCEPTION_OUT);
	c_view: cover property (mv && s == 5'h1a);
endmodule
bind fpcw_core fpcw_core_chk fpcw_core_chk_i (.*);

// *** verif/fpcw_core_tb.sv ***
`include "fpcw_map.vh"
module fpcw_core_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic REF_CLK_IN = 0, RST_B_IN = 0, CLK_EN_IN = 1, ISSUE_VALID_IN = 0, COP1_USABLE_IN = 1, SECOND_COPROC_OPERATION_USABLE_IN = 1;
	logic CONVERT_INVALID_IN, DEST_WRITE_OUT, FP_EXCEPTION_OUT, UNUSABLE_EXCEPTION_OUT, RESERVED_EXCEPTION_OUT;
	logic CP2_CTRL_WRITE_OUT, CP2_OPER_OUT, DONE_OUT;
	logic [1:0] ROUND_MODE_OUT;
	logic [2:0] ISSUE_OP_IN = 3'h0;
	logic [4:0] FLOAT_SOURCE_REGISTER_IN = 5'h00, FORMAT_IN = `FPCW_FMT_S;
	logic [15:0] IMPL_FIELD_IN = 16'h5a3c, CP2_SELECT_OUT;
	logic [24:0] COFUN_IN = 25'h1abcdef, CP2_FUNC_OUT;
	logic [31:0] ISSUE_PC_IN = 32'h0, FP_CONTROL_STATUS_OUT, EXCEPTION_RETURN_ADDRESS_OUT, CP2_DATA_OUT;
	logic [63:0] GENERAL_REGISTER_IN = 64'h0, FLOAT_SOURCE_IN = 64'h0, FLOAT_SECOND_SOURCE_IN = 64'hfedcba9876543210;
	logic [63:0] CONVERT_RESULT_IN, DEST_DATA_OUT;
	int n_fail = 0, checks_done = 0, cyc = 0;
	fpcw_core fpcw_core_i (.*);
	fpcw_arith_model fpcw_arith_model_i (.src_in(FLOAT_SOURCE_IN), .res_out(CONVERT_RESULT_IN),
		.inv_out(CONVERT_INVALID_IN));
	always #25 REF_CLK_IN = ~REF_CLK_IN;
	// Hang guard: the run needs about 56 cycles, far below the 1000-cycle limit
	always @(posedge REF_CLK_IN) begin
		cyc++;
		if (cyc == 1000) begin
			n_fail++;
			summarize;
		end
	end
	task summarize;
		if (n_fail == 0 && checks_done > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	task chk(input string n, input [63:0] e, input [63:0] v);
		checks_done++;
		if (v !== e) begin
			n_fail++;
			$display("[ERR] %s exp %h got %h", n, e, v);
		end
	endtask
	// One issue, judged just after the edge where its answer lands
	task iss(input [2:0] o, input [4:0] s, input [63:0] g);
		@(posedge REF_CLK_IN);
		ISSUE_VALID_IN <= 1;
		ISSUE_OP_IN <= o;
		FLOAT_SOURCE_REGISTER_IN <= s;
		GENERAL_REGISTER_IN <= g;
		ISSUE_PC_IN <= ISSUE_PC_IN + 32'h4;
		@(posedge REF_CLK_IN);
		ISSUE_VALID_IN <= 0;
		#1 chk("done", 1, DONE_OUT);
	endtask
	task mv(input [4:0] s, input [31:0] g, input [31:0] f, input x);
		iss(3'h1, s, {32'hffffffff, g});
		chk("status", f, FP_CONTROL_STATUS_OUT);
		chk("fpexc", x, FP_EXCEPTION_OUT);
	endtask
	task cv(input [2:0] o, input [4:0] m, input [63:0] s);
		@(posedge REF_CLK_IN);
		FORMAT_IN <= m;
		FLOAT_SOURCE_IN <= s;
		iss(o, 5'h00, 64'h0); // full register file only, never 16-register mode
	endtask
	task t_views;
		mv(5'h1f, 32'h3, 32'h3, 0);
		chk("round", 2'h3, ROUND_MODE_OUT);
		mv(5'h1f, 32'h1080, 32'h1080, 1);
		chk("epc", ISSUE_PC_IN, EXCEPTION_RETURN_ADDRESS_OUT);
		mv(5'h1f, 32'h0, 32'h0, 0);
		mv(5'h19, 32'hff, 32'hfe800000, 0);
		mv(5'h1c, 32'hf87, 32'hff800f83, 0);
		mv(5'h1a, 32'h1000, 32'hff801f83, 1);
		mv(5'h1a, 32'h1001, 32'hff801f83, 0);
		mv(5'h1b, 32'h0, 32'hff801f83, 0);
		mv(5'h1f, 32'h40000, 32'hff801f83, 0);
	endtask
	task t_cp2;
		iss(3'h2, 5'h00, 64'hdeadbeefcafef00d);
		chk("cp2wr", 1, CP2_CTRL_WRITE_OUT);
		chk("cp2data", 32'hcafef00d, CP2_DATA_OUT);
		chk("cp2sel", 16'h5a3c, CP2_SELECT_OUT);
		iss(3'h3, 5'h00, 64'h0);
		chk("cp2op", 1, CP2_OPER_OUT);
		chk("cp2fn", 25'h1abcdef, CP2_FUNC_OUT);
	endtask
	task t_conv;
		mv(5'h1f, 32'h800, 32'h800, 0);
		cv(3'h6, `FPCW_FMT_S, 64'h0123456789abcdef);
		chk("pair", 64'h89abcdef76543210, DEST_DATA_OUT);
		chk("pairexc", 0, FP_EXCEPTION_OUT);
		chk("pairwr", 1, DEST_WRITE_OUT);
		cv(3'h4, `FPCW_FMT_W, 64'h0123456789abcdef);
		chk("dbl", 64'h89abcdef01234567, DEST_DATA_OUT);
		cv(3'h7, `FPCW_FMT_W, 64'h0123456789abcdef);
		chk("sgl", 64'h89abcdef01234567, DEST_DATA_OUT);
		cv(3'h5, `FPCW_FMT_D, 64'h7ff0000000000000);
		chk("ltrap", 1, FP_EXCEPTION_OUT);
		chk("lwrite", 0, DEST_WRITE_OUT);
		chk("status", 32'h10840, FP_CONTROL_STATUS_OUT);
		mv(5'h1f, 32'h0, 32'h0, 0);
		cv(3'h5, `FPCW_FMT_D, 64'h7ff0000000000000);
		chk("lmax", `FPCW_LONG_MAX, DEST_DATA_OUT);
		cv(3'h5, `FPCW_FMT_W, 64'h0);
		chk("resv", 1, RESERVED_EXCEPTION_OUT);
		chk("resvwr", 0, DEST_WRITE_OUT);
	endtask
	task t_unus;
		@(posedge REF_CLK_IN) COP1_USABLE_IN <= 0;
		iss(3'h1, 5'h1f, 64'h3);
		chk("unus", 1, UNUSABLE_EXCEPTION_OUT);
		chk("status", 32'h10040, FP_CONTROL_STATUS_OUT);
		@(posedge REF_CLK_IN) COP1_USABLE_IN <= 1;
		SECOND_COPROC_OPERATION_USABLE_IN <= 0;
		iss(3'h2, 5'h00, 64'h1);
		chk("unus2", 1, UNUSABLE_EXCEPTION_OUT);
		chk("cp2wr0", 0, CP2_CTRL_WRITE_OUT);
		@(posedge REF_CLK_IN) SECOND_COPROC_OPERATION_USABLE_IN <= 1;
	endtask
	initial begin
		repeat (5) @(posedge REF_CLK_IN);
		RST_B_IN <= 1;
		t_views;
		t_cp2;
		t_conv;
		t_unus;
		summarize;
	end
endmodule
